// ==== core/ebse_pkg.sv ====
// Constants, types and descriptor layout for the expansion bus service engine.
// Assumes one 200 MHz clock; the expansion clock period equals one clk_i period.
// Contract
// - Command code six writes, seven reads
// - Completion interrupt pulse only when enabled
// - Hold flag clear: address increments per access
// - Hold flag set: address stays fixed
// - Descriptor byte enables driven active low
// - Length field gives transaction count
// - Base address starts first transaction
// - Host memory bursts at most 32 dwords
// - Read data buffered then burst to host
// - Write data fetched first, then written out
// - Expansion clock is inverted system clock
// - Clock enable clear tri-states clock output
// - After reset clock disabled and tri-stated
// - Address held one plus setting periods
// - Pre and post address cycles added
// - Data held one plus setting periods
// - Pre and post data cycles added
// - Timing runs with clock output disabled
// - Request bus, wait for grant first
// - Strobe style selects strobe protocol
package ebse_pkg;
  localparam logic [4:0] EBSE_OP_WRITE = 5'h06;
  localparam logic [4:0] EBSE_OP_READ = 5'h07;
  localparam int EBSE_OP_MSB = 31;
  localparam int EBSE_OP_LSB = 27;
  localparam int EBSE_IRQEN_BIT = 26;
  localparam int EBSE_HOLD_BIT = 18;
  localparam int EBSE_BE_MSB = 17;
  localparam int EBSE_BE_LSB = 14;
  localparam int EBSE_LEN_MSB = 13;
  localparam int EBSE_BURST_MAX = 32;
  localparam int EBSE_BUF_AW = 5;
  // Wishbone register offsets (byte addresses)
  localparam logic [3:0] EBSE_REG_CFG = 4'h0;
  localparam logic [3:0] EBSE_REG_DESC0 = 4'h4;
  localparam logic [3:0] EBSE_REG_PTR = 4'h8;
  localparam logic [3:0] EBSE_REG_BASE = 4'hc;
  // Configuration fields
  localparam int EBSE_CFG_CKEN_BIT = 0;
  localparam int EBSE_CFG_STYLE_BIT = 1;
  localparam int EBSE_CFG_ADUR_LSB = 4;
  localparam int EBSE_CFG_DDUR_LSB = 8;
  localparam int EBSE_CFG_GO_BIT = 31;
  localparam logic [31:0] EBSE_CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] EBSE_BAD_DATA = 32'hdead_0000;

  typedef enum logic [3:0] {
    EBSE_IDLE = 4'h0,
    EBSE_FETCH = 4'h1,
    EBSE_REQ = 4'h2,
    EBSE_PREA = 4'h3,
    EBSE_ADDR = 4'h4,
    EBSE_POSTA = 4'h5,
    EBSE_PRED = 4'h6,
    EBSE_DATA = 4'h7,
    EBSE_POSTD = 4'h8,
    EBSE_STORE = 4'h9,
    EBSE_DONE = 4'ha
  } ebse_state_type;

  // Host memory master request: a one-dword beat of a burst
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic last;
  } ebse_mem_req_type;

  // Expansion bus strobes, active low except rnw (high for read)
  typedef struct packed {
    logic ale_n;
    logic rd_n;
    logic wr_n;
    logic ds_n;
    logic rnw;
  } ebse_strobe_type;
endpackage

// ==== core/ebse_engine.sv ====
// Expansion bus service engine: Wishbone descriptor port, host memory burst port, expansion bus pins.
// Assumes a memory fabric answering each beat with mem_ack_i; grant and data pins arrive asynchronously.
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module ebse_engine
  import ebse_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output ebse_mem_req_type mem_req_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  output logic completion_irq_o,
  output logic busy_o,
  output logic expansion_clock_out_o,
  output logic expansion_clock_oe_n_o,
  output logic bus_request_o,
  input wire logic bus_grant_in_i,
  output logic [31:0] expansion_addr_data_lines_o,
  output logic expansion_addr_data_oe_n_o,
  input wire logic [31:0] expansion_addr_data_lines_i,
  output logic [3:0] byte_lane_enables_n_o,
  output ebse_strobe_type strobe_o
);
  logic [31:0] cfg_q;
  logic [31:0] desc0_q;
  logic [31:0] ptr_q;
  logic [31:0] base_q;
  ebse_state_type state_q;
  logic [31:0] buf_mem [EBSE_BURST_MAX];
  logic [13:0] total_q;
  logic [13:0] left_q;
  logic [5:0] chunk_q;
  logic [5:0] idx_q;
  logic [2:0] dur_q;
  logic [31:0] eaddr_q;
  logic [31:0] maddr_q;
  logic grant_s1_q;
  logic grant_s2_q;
  logic [31:0] din_s1_q;
  logic [31:0] din_s2_q;
  logic cap1_q;
  logic cap2_q;
  logic [4:0] cap_idx1_q;
  logic [4:0] cap_idx2_q;
  logic clk_run_q;
  logic is_read;
  logic [5:0] chunk_d;
  logic wb_hit;
  logic [31:0] rd_mux;

  assign is_read = (desc0_q[EBSE_OP_MSB:EBSE_OP_LSB] == EBSE_OP_READ);
  assign chunk_d = (left_q > 14'(EBSE_BURST_MAX)) ? 6'(EBSE_BURST_MAX) : left_q[5:0];
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb
  begin
    case (wb_adr_i)
      EBSE_REG_CFG: rd_mux = {busy_o, cfg_q[30:0]};
      EBSE_REG_DESC0: rd_mux = desc0_q;
      EBSE_REG_PTR: rd_mux = ptr_q;
      EBSE_REG_BASE: rd_mux = base_q;
      default: rd_mux = EBSE_BAD_DATA;
    endcase
  end

  // Register slave, one wait state, writes ignored while busy
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      cfg_q <= EBSE_CFG_RESET;
      desc0_q <= 32'h0000_0000;
      ptr_q <= 32'h0000_0000;
      base_q <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? rd_mux : wb_dat_o;
      if (state_q == EBSE_DONE)
        cfg_q[EBSE_CFG_GO_BIT] <= 1'b0;
      if (wb_hit && wb_we_i && !busy_o)
      begin
        for (int b = 0; b < 4; b++)
        begin
          if (wb_sel_i[b])
          begin
            case (wb_adr_i)
              EBSE_REG_CFG: cfg_q[8*b+:8] <= wb_dat_i[8*b+:8];
              EBSE_REG_DESC0: desc0_q[8*b+:8] <= wb_dat_i[8*b+:8];
              EBSE_REG_PTR: ptr_q[8*b+:8] <= wb_dat_i[8*b+:8];
              EBSE_REG_BASE: base_q[8*b+:8] <= wb_dat_i[8*b+:8];
              default: ;
            endcase
          end
        end
      end
    end
  end

  // Grant synchroniser
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      grant_s1_q <= 1'b0;
      grant_s2_q <= 1'b0;
    end
    else if (ce_i)
    begin
      grant_s1_q <= bus_grant_in_i;
      grant_s2_q <= grant_s1_q;
    end
  end

  // Data line synchroniser and delayed capture
  // Peripheral holds the word over the strobe, so the whole word passes both flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      din_s1_q <= 32'h0000_0000;
      din_s2_q <= 32'h0000_0000;
      cap1_q <= 1'b0;
      cap2_q <= 1'b0;
      cap_idx1_q <= 5'h00;
      cap_idx2_q <= 5'h00;
    end
    else if (ce_i)
    begin
      din_s1_q <= expansion_addr_data_lines_i;
      din_s2_q <= din_s1_q;
      cap1_q <= (state_q == EBSE_POSTD) && is_read;
      cap2_q <= cap1_q;
      cap_idx1_q <= idx_q[4:0];
      cap_idx2_q <= cap_idx1_q;
    end
  end

  // Sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= EBSE_IDLE;
      total_q <= 14'h0000;
      left_q <= 14'h0000;
      chunk_q <= 6'h00;
      idx_q <= 6'h00;
      dur_q <= 3'h0;
      eaddr_q <= 32'h0000_0000;
      maddr_q <= 32'h0000_0000;
      busy_o <= 1'b0;
      completion_irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      completion_irq_o <= 1'b0;
      case (state_q)
        EBSE_IDLE:
        begin
          if (cfg_q[EBSE_CFG_GO_BIT] && !busy_o)
          begin
            busy_o <= 1'b1;
            total_q <= desc0_q[EBSE_LEN_MSB:0];
            left_q <= desc0_q[EBSE_LEN_MSB:0];
            eaddr_q <= base_q;
            maddr_q <= {ptr_q[31:2], 2'b00};
            idx_q <= 6'h00;
            chunk_q <= 6'h00;
            state_q <= EBSE_DONE;
            if (desc0_q[EBSE_OP_MSB:EBSE_OP_LSB] == EBSE_OP_WRITE
                || desc0_q[EBSE_OP_MSB:EBSE_OP_LSB] == EBSE_OP_READ)
              state_q <= (desc0_q[EBSE_LEN_MSB:0] == 14'h0000) ? EBSE_DONE : EBSE_REQ;
          end
        end
        EBSE_REQ:
        begin
          if (chunk_q == 6'h00)
          begin
            chunk_q <= chunk_d;
            idx_q <= 6'h00;
            if (!is_read)
              state_q <= EBSE_FETCH;
          end
          else if (grant_s2_q)
          begin
            state_q <= EBSE_PREA;
          end
        end
        EBSE_FETCH:
        begin
          if (mem_ack_i)
          begin
            maddr_q <= maddr_q + 32'h0000_0004;
            if (idx_q == chunk_q - 6'h01)
            begin
              idx_q <= 6'h00;
              state_q <= EBSE_REQ;
            end
            else
              idx_q <= idx_q + 6'h01;
          end
        end
        EBSE_PREA:
        begin
          dur_q <= {1'b0, cfg_q[EBSE_CFG_ADUR_LSB+:2]};
          state_q <= EBSE_ADDR;
        end
        EBSE_ADDR:
        begin
          dur_q <= dur_q - 3'h1;
          if (dur_q == 3'h0)
            state_q <= EBSE_POSTA;
        end
        EBSE_POSTA: state_q <= EBSE_PRED;
        EBSE_PRED:
        begin
          dur_q <= cfg_q[EBSE_CFG_DDUR_LSB+:3];
          state_q <= EBSE_DATA;
        end
        EBSE_DATA:
        begin
          dur_q <= dur_q - 3'h1;
          if (dur_q == 3'h0)
            state_q <= EBSE_POSTD;
        end
        EBSE_POSTD:
        begin
          if (!desc0_q[EBSE_HOLD_BIT])
            eaddr_q <= eaddr_q + 32'h0000_0001;
          // Address unchanged when the hold flag is set
          left_q <= left_q - 14'h0001;
          if (idx_q == chunk_q - 6'h01)
          begin
            idx_q <= 6'h00;
            state_q <= is_read ? EBSE_STORE : EBSE_REQ;
            if (!is_read)
              chunk_q <= 6'h00;
            if (!is_read && left_q == 14'h0001)
              state_q <= EBSE_DONE;
          end
          else
          begin
            idx_q <= idx_q + 6'h01;
            state_q <= EBSE_PREA;
          end
        end
        EBSE_STORE:
        begin
          if (mem_ack_i)
          begin
            maddr_q <= maddr_q + 32'h0000_0004;
            if (idx_q == chunk_q - 6'h01)
            begin
              idx_q <= 6'h00;
              chunk_q <= 6'h00;
              state_q <= (left_q == 14'h0000) ? EBSE_DONE : EBSE_REQ;
            end
            else
              idx_q <= idx_q + 6'h01;
          end
        end
        EBSE_DONE:
        begin
          busy_o <= 1'b0;
          completion_irq_o <= desc0_q[EBSE_IRQEN_BIT] && (total_q != 14'h0000 || 1'b1);
          state_q <= EBSE_IDLE;
        end
        default: state_q <= EBSE_IDLE;
      endcase
    end
  end

  // Transfer buffer
  always_ff @(posedge clk_i)
  begin
    if (ce_i && !rst_i)
    begin
      if (state_q == EBSE_FETCH && mem_ack_i)
        buf_mem[idx_q[4:0]] <= mem_rdata_i;
      if (cap2_q)
        buf_mem[cap_idx2_q] <= din_s2_q;
    end
  end

  // Host memory request beats
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mem_req_o <= '0;
    else if (ce_i)
    begin
      // Store beats wait until the last captured word is in the buffer
      mem_req_o.valid <= (state_q == EBSE_FETCH || (state_q == EBSE_STORE && !cap1_q && !cap2_q))
                         && !mem_ack_i;
      mem_req_o.write <= (state_q == EBSE_STORE);
      mem_req_o.addr <= maddr_q;
      mem_req_o.wdata <= buf_mem[idx_q[4:0]];
      mem_req_o.last <= (idx_q == chunk_q - 6'h01);
    end
  end

  // Expansion bus pins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_request_o <= 1'b0;
      expansion_addr_data_lines_o <= 32'h0000_0000;
      expansion_addr_data_oe_n_o <= 1'b1;
      byte_lane_enables_n_o <= 4'hf;
      strobe_o <= 5'h1f;
      expansion_clock_oe_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      expansion_clock_oe_n_o <= !cfg_q[EBSE_CFG_CKEN_BIT];
      bus_request_o <= (state_q == EBSE_REQ && chunk_q != 6'h00) || (state_q >= EBSE_PREA && state_q <= EBSE_POSTD);
      byte_lane_enables_n_o <= (state_q >= EBSE_PREA && state_q <= EBSE_POSTD)
                               ? ~desc0_q[EBSE_BE_MSB:EBSE_BE_LSB] : 4'hf;
      if (state_q == EBSE_PREA || state_q == EBSE_ADDR)
      begin
        expansion_addr_data_lines_o <= eaddr_q;
        expansion_addr_data_oe_n_o <= 1'b0;
      end
      else if (!is_read && (state_q == EBSE_PRED || state_q == EBSE_DATA))
      begin
        expansion_addr_data_lines_o <= buf_mem[idx_q[4:0]];
        expansion_addr_data_oe_n_o <= 1'b0;
      end
      else
        expansion_addr_data_oe_n_o <= 1'b1;
      strobe_o.ale_n <= !(state_q >= EBSE_ADDR && state_q <= EBSE_POSTD);
      strobe_o.rnw <= is_read;
      if (!cfg_q[EBSE_CFG_STYLE_BIT])
      begin
        strobe_o.rd_n <= !(is_read && state_q == EBSE_DATA);
        strobe_o.wr_n <= !(!is_read && state_q == EBSE_DATA);
        strobe_o.ds_n <= 1'b1;
      end
      else
      begin
        strobe_o.rd_n <= 1'b1;
        strobe_o.wr_n <= 1'b1;
        strobe_o.ds_n <= !(state_q == EBSE_DATA);
      end
    end
  end

  // Inverted clock: held low in reset, then follows ~clk_i
  always_ff @(negedge clk_i)
  begin
    if (rst_i)
      clk_run_q <= 1'b0;
    else
      clk_run_q <= 1'b1;
  end
  assign expansion_clock_out_o = clk_run_q & ~clk_i;
endmodule // ebse_engine
`default_nettype wire

// ==== verification/ebse_props.sv ====
// Port checker for the service engine: register answers, clock pin, bursts, strobe timing.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ebse_props
  import ebse_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire ebse_mem_req_type mem_req_o,
  input wire logic mem_ack_i,
  input wire logic completion_irq_o,
  input wire logic busy_o,
  input wire logic expansion_clock_oe_n_o,
  input wire logic bus_request_o,
  input wire logic bus_grant_in_i,
  input wire ebse_strobe_type strobe_o
);
  logic strb_n;
  logic cfg_wr;
  logic ck_q;
  logic [1:0] ad_q;
  logic [2:0] dd_q;
  logic [5:0] beats_q;
  logic [3:0] run_q;
  logic [4:0] gap_q;
  assign strb_n = strobe_o.rd_n & strobe_o.wr_n & strobe_o.ds_n;
  assign cfg_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & ~busy_o & (wb_adr_i == EBSE_REG_CFG);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ck_q <= 1'b0;
      ad_q <= 2'h0;
      dd_q <= 3'h0;
      beats_q <= 6'h0;
      run_q <= 4'h0;
      gap_q <= 5'h0;
    end
    else
    begin
      if (cfg_wr)
      begin
        ck_q <= wb_dat_i[EBSE_CFG_CKEN_BIT];
        ad_q <= wb_dat_i[EBSE_CFG_ADUR_LSB+:2];
        dd_q <= wb_dat_i[EBSE_CFG_DDUR_LSB+:3];
      end
      if (mem_req_o.valid && mem_ack_i)
        beats_q <= mem_req_o.last ? 6'h0 : beats_q + 6'h1;
      run_q <= strb_n ? 4'h0 : run_q + 4'h1;
      gap_q <= strobe_o.ale_n ? 5'h0 : (strb_n ? gap_q + 5'h1 : gap_q);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_wb_answer; s_take |=> s_answer; endproperty
  a_wb_answer: assert property (p_wb_answer) else $error("register answer late or long");
  property p_clk_reset; $fell(rst_i) |-> expansion_clock_oe_n_o && !busy_o; endproperty
  a_clk_reset: assert property (p_clk_reset) else $error("clock pin driven after reset");
  property p_clk_en; $past(cfg_wr, 3) |-> expansion_clock_oe_n_o == !ck_q; endproperty
  a_clk_en: assert property (p_clk_en) else $error("clock enable not followed");
  property p_irq_pulse; completion_irq_o |=> !completion_irq_o; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("completion pulse too long");
  property p_irq_last; completion_irq_o |-> !mem_req_o.valid && !bus_request_o; endproperty
  a_irq_last: assert property (p_irq_last) else $error("completion before traffic ended");
  property p_burst; mem_req_o.valid && mem_ack_i |-> beats_q < EBSE_BURST_MAX; endproperty
  a_burst: assert property (p_burst) else $error("memory burst too long");
  property p_grant; $fell(strobe_o.ale_n) |-> bus_request_o && $past(bus_grant_in_i, 2); endproperty
  a_grant: assert property (p_grant) else $error("bus cycle without grant");
  property p_data_len; $rose(strb_n) |-> run_q == dd_q + 4'h1; endproperty
  a_data_len: assert property (p_data_len) else $error("data strobe width wrong");
  property p_addr_len; $fell(strb_n) |-> gap_q == ad_q + 5'h3; endproperty
  a_addr_len: assert property (p_addr_len) else $error("address phase length wrong");
endmodule // ebse_props
bind ebse_engine ebse_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
  .wb_ack_o, .mem_req_o, .mem_ack_i, .completion_irq_o, .busy_o, .expansion_clock_oe_n_o, .bus_request_o,
  .bus_grant_in_i, .strobe_o);
`default_nettype wire

// ==== verification/ebse_partner.sv ====
// Far side model: host memory, bus arbiter and one peripheral on the shared lines.
// Assumes registered engine outputs; memory starts with a known pattern.
`timescale 1ns/1ps
`default_nettype none
module ebse_partner
  import ebse_pkg::*;
(
  input wire logic clk_i,
  input wire logic req_i,
  output logic gnt_o,
  input wire ebse_mem_req_type mem_i,
  output logic ack_o,
  output logic [31:0] rdata_o,
  input wire logic [31:0] drv_i,
  input wire logic drv_oe_n_i,
  input wire logic ale_n_i,
  output logic [31:0] bus_o
);
  logic [31:0] mem [0:255];
  logic [31:0] adr_q;
  logic [31:0] last_q;
  logic ale_q;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 32'hc0de_0000 | i;
  end
  assign rdata_o = mem[mem_i.addr[9:2]];
  // Released lines toggle while ale_n is high so no stale value survives
  assign bus_o = !drv_oe_n_i ? drv_i : (!ale_n_i ? adr_q ^ 32'h0f0f_a5a5 : ~last_q);
  always @(posedge clk_i)
  begin
    gnt_o <= req_i && (gnt_o || $urandom_range(2) == 0);
    ack_o <= mem_i.valid && !ack_o && $urandom_range(1) == 1;
    if (mem_i.valid && mem_i.write && ack_o)
      mem[mem_i.addr[9:2]] <= mem_i.wdata;
    ale_q <= ale_n_i;
    if (ale_q && !ale_n_i)
      adr_q <= drv_i;
    last_q <= bus_o;
  end
endmodule // ebse_partner
`default_nettype wire

// ==== verification/expansion_bus_service_engine_tb.sv ====
// Bench: descriptor requests over Wishbone; a monitor checks bus cycles and memory stores.
// Assumes the far side model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module expansion_bus_service_engine_tb import ebse_pkg::*;;
  typedef struct packed {
    logic mem;
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0] be_n;
    logic [3:0] dir;
  } ebse_note_type;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, mem_rdata_i, expansion_addr_data_lines_o, expansion_addr_data_lines_i, rd, m_adr, m_dat;
  logic wb_ack_o, mem_ack_i, completion_irq_o, busy_o, expansion_clock_out_o, expansion_clock_oe_n_o;
  logic bus_request_o, bus_grant_in_i, expansion_addr_data_oe_n_o;
  logic ale_p = 1'b1;
  logic [3:0] byte_lane_enables_n_o, m_be;
  logic [3:0] m_dir = 4'h0;
  logic m_oe;
  ebse_mem_req_type mem_req_o;
  ebse_strobe_type strobe_o;
  ebse_note_type notes [$];
  ebse_note_type nt;
  int fail_count = 0;
  int n_tests = 0;
  int irq_seen = 0;
  int irq_exp = 0;
  int cycles = 0;
  logic [4:0] ops [0:6] = '{5'h06, 5'h07, 5'h06, 5'h07, 5'h05, 5'h07, 5'h06};
  logic [13:0] lens [0:6] = '{14'h3, 14'h3, 14'h22, 14'h22, 14'h2, 14'h0, 14'h5};
  always #2.5 clk_i = ~clk_i;
  ebse_engine dut (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf),
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .mem_req_o, .mem_ack_i, .mem_rdata_i, .completion_irq_o, .busy_o,
    .expansion_clock_out_o, .expansion_clock_oe_n_o, .bus_request_o, .bus_grant_in_i,
    .expansion_addr_data_lines_o, .expansion_addr_data_oe_n_o, .expansion_addr_data_lines_i,
    .byte_lane_enables_n_o, .strobe_o);
  ebse_partner u_far (.clk_i, .req_i(bus_request_o), .gnt_o(bus_grant_in_i), .mem_i(mem_req_o),
    .ack_o(mem_ack_i), .rdata_o(mem_rdata_i), .drv_i(expansion_addr_data_lines_o),
    .drv_oe_n_i(expansion_addr_data_oe_n_o), .ale_n_i(strobe_o.ale_n), .bus_o(expansion_addr_data_lines_i));
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic take(output ebse_note_type n);
    n = '0;
    if (notes.size() == 0)
      check("event count", 32'h1, 32'h0);
    else
      n = notes.pop_front();
  endtask
  task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic run_req(input logic [4:0] op, input logic ie, input logic hold, input logic [13:0] len,
    input logic ck);
    logic [31:0] ptr, base, a;
    logic [3:0] be;
    logic [1:0] ad;
    logic [2:0] dd;
    logic st;
    logic rdop;
    be = $urandom();
    base = $urandom();
    ad = $urandom();
    dd = $urandom();
    st = $urandom();
    rdop = (op == EBSE_OP_READ);
    ptr = rdop ? 32'h200 : 32'h40;
    irq_exp += ie;
    for (int i = 0; i < len; i += EBSE_BURST_MAX)
      for (int p = 0; p < 2; p++)
        for (int j = i; j < len && j < i + EBSE_BURST_MAX; j++)
        begin
          a = hold ? base : base + j;
          if (p == 0 && op == EBSE_OP_WRITE)
            notes.push_back('{1'b0, a, 32'hc0de_0000 | (ptr[9:2] + j), ~be, st ? 4'h2 : 4'h4});
          if (p == 0 && rdop)
            notes.push_back('{1'b0, a, 32'h0, ~be, st ? 4'h3 : 4'h8});
          if (p == 1 && rdop)
            notes.push_back('{1'b1, ptr + 4 * j, a ^ 32'h0f0f_a5a5, 4'h0, 4'h0});
        end
    wb_cycle(1'b1, EBSE_REG_DESC0, {op, ie, 7'h00, hold, be, len});
    wb_cycle(1'b1, EBSE_REG_PTR, ptr);
    wb_cycle(1'b1, EBSE_REG_BASE, base);
    wb_cycle(1'b1, EBSE_REG_CFG, {1'b1, 20'h0, dd, 2'b00, ad, 2'b00, st, ck});
    repeat (3) @(posedge clk_i);
    while (busy_o !== 1'b0)
      @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    check("completions", irq_seen, irq_exp);
    check("events left", notes.size(), 32'h0);
    check("clock oe_n", expansion_clock_oe_n_o, !ck);
  endtask
  always @(posedge clk_i)
  begin
    if (!rst_i)
    begin
      irq_seen += (completion_irq_o === 1'b1);
      if (mem_req_o.valid && mem_req_o.write && mem_ack_i)
      begin
        take(nt);
        check("store adr", {nt.mem, mem_req_o.addr}, {1'b1, nt.adr});
        check("store dat", mem_req_o.wdata, nt.dat);
      end
      if (ale_p && !strobe_o.ale_n)
        m_adr = expansion_addr_data_lines_o;
      if (!(strobe_o.rd_n && strobe_o.wr_n && strobe_o.ds_n))
      begin
        m_dir = m_dir | {~strobe_o.rd_n, ~strobe_o.wr_n, ~strobe_o.ds_n, ~strobe_o.ds_n & strobe_o.rnw};
        m_be = byte_lane_enables_n_o;
        m_oe = expansion_addr_data_oe_n_o;
        m_dat = expansion_addr_data_lines_o;
      end
      if (!ale_p && strobe_o.ale_n)
      begin
        take(nt);
        check("bus adr", {nt.mem, m_adr}, {1'b0, nt.adr});
        check("bus dir", m_dir, nt.dir);
        check("bus be", m_be, nt.be_n);
        check("bus dat", (nt.dir[3] | nt.dir[0]) ? 32'h0 : m_dat, nt.dat);
        check("bus oe_n", m_oe, nt.dir[3] | nt.dir[0]);
        m_dir = 4'h0;
      end
      ale_p = strobe_o.ale_n;
    end
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      stop_test();
    end
  end
  initial
  begin
    void'($urandom(32'hef3f));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_cycle(1'b0, EBSE_REG_CFG, 32'h0);
    check("cfg reset", rd, EBSE_CFG_RESET);
    check("clock oe_n", expansion_clock_oe_n_o, 32'h1);
    @(negedge clk_i);
    #1;
    check("clock out high", expansion_clock_out_o, 33'h1);
    @(posedge clk_i);
    #1;
    check("clock out low", expansion_clock_out_o, 33'h0);
    for (int k = 0; k < 7; k++)
      run_req(ops[k], k != 0, k[1], lens[k], k != 2);
    wb_cycle(1'b1, EBSE_REG_CFG, 32'h0);
    repeat (3) @(posedge clk_i);
    check("clock oe_n", expansion_clock_oe_n_o, 32'h1);
    stop_test();
  end
endmodule // expansion_bus_service_engine_tb
`default_nettype wire
